// *** rtl/accessory_impedance_detect.sv ***
`timescale 1ns/1ps
`include "impdet_consts.svh"
module accessory_impedance_detect
  import impdet_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int LS_CYC = `CLK_HZ / `LS_HZ
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // mic sense measurement front end
  output logic                   mic_meas_go,
  output logic                   sense_pin_select,
  input  wire logic              mic_meas_done,
  input  wire logic [2:0]        mic_meas_band,
  input  wire logic [6:0]        mic_meas_adc,
  // bias outputs
  output logic      [3:0]        bias_output_en,
  output logic      [3:0]        bias_slow_ramp,
  output logic      [3:0]        bias_discharge_on,
  // phone sense front end
  output logic                   hp_sense_go,
  output logic                   hp_sweep_step,
  output logic      [1:0]        hp_range_out,
  output logic                   hp_on_mic_pin,
  output logic      [2:0]        detect_function_select,
  input  wire logic              hp_sense_done,
  input  wire logic [9:0]        hp_meas_up,
  input  wire logic [9:0]        hp_meas_down,
  // phone drivers
  output logic                   left_phone_driver_on,
  output logic                   right_phone_driver_on
);

  localparam logic [11:0] LS_LAST = 12'(LS_CYC - 1);

  state_t s_q;
  state_t s_d;
  logic   ls_tick;
  logic   run;
  logic   need_bias;
  logic   wr;
  logic   trig_wr;
  logic   setup;
  logic [9:0] widx;
  logic [6:0] sw_last;
  logic [2:0] folded;

  // fold a raw band down onto the nearest enabled band
  function automatic logic [2:0] fold_band(input logic [2:0] raw,
                                           input logic [7:0] en);
    logic [7:0] ok;
    logic [2:0] r;
    ok = {1'b1, en[7], en[4:0], 1'b1};
    r  = raw;
    for (int i = 0; i < 7; i++) begin
      if (!ok[r]) r = r - 3'd1;
    end
    return r;
  endfunction : fold_band

  // band index to one-hot result field, empty for index 7
  function automatic logic [8:0] band_bits(input logic [2:0] idx);
    logic [8:0] b;
    b = 9'h000;
    unique case (idx)
      3'd6:    b[8] = 1'b1;
      3'd7:    b = 9'h000;
      default: b[idx] = 1'b1;
    endcase
    return b;
  endfunction : band_bits

  // bus decode and derived controls
  assign setup     = psel && !penable;
  assign wr        = psel && penable && pwrite;
  assign widx      = paddr[ADDR_W-1:2];
  assign trig_wr   = wr && widx == `IDX_HPCTL && pwdata[0];
  assign ls_tick   = s_q.ls_cnt == LS_LAST;
  assign run       = s_q.mic_on && (s_q.fsel == `FN_DISCRETE || s_q.fsel == `FN_ADC);
  assign need_bias = s_q.ref_sel != 2'd0 && !s_q.bon[s_q.ref_sel];
  assign sw_last   = 7'(({4'd0, s_q.hdiv} + 7'd1) << s_q.hrate);
  assign folded    = fold_band(mic_meas_band, s_q.lvl_en);

  // outputs
  assign pready  = 1'b1;
  assign prdata  = s_q.prdata;
  assign pslverr = s_q.slverr;
  assign mic_meas_go      = s_q.mst == M_MEAS;
  assign sense_pin_select = s_q.pin_sel;
  assign bias_slow_ramp   = s_q.bslow;
  assign bias_discharge_on = s_q.bdis;
  assign hp_sense_go      = s_q.hst == H_RUN;
  assign hp_sweep_step    = s_q.hst == H_RUN && s_q.sw_cnt == sw_last - 7'd1;
  assign hp_on_mic_pin    = s_q.fsel == `FN_HP_MIC;
  assign hp_range_out     = hp_on_mic_pin ? 2'b00 : s_q.range;
  assign detect_function_select = s_q.fsel;
  assign left_phone_driver_on  = s_q.drv_l;
  assign right_phone_driver_on = s_q.drv_r;

  // bias enables: software level or automatic per measurement
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bias_output_en[i] = s_q.bon[i] ||
        (s_q.ref_sel == 2'(i) && i != 0 &&
         (s_q.mst == M_SETTLE || s_q.mst == M_MEAS));
    end
  end

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.ls_cnt = ls_tick ? 12'd0 : s_q.ls_cnt + 12'd1;
    // register read data captured in the setup cycle
    if (setup) begin
      s_d.prdata = 32'h0000_0000;
      s_d.slverr = 1'b0;
      unique case (widx)
        `IDX_CTRL:   s_d.prdata = {16'h0000, s_q.repeat_dly, s_q.settle, 1'b0,
                                   s_q.ref_sel, s_q.pin_sel, s_q.fsel, s_q.mic_on};
        `IDX_BIAS:   s_d.prdata = {20'h00000, s_q.bdis, s_q.bslow, s_q.bon};
        `IDX_LVLSEL: s_d.prdata = {24'h000000, s_q.lvl_en};
        `IDX_STATUS: s_d.prdata = {21'h000000, s_q.band, s_q.valid, s_q.present};
        `IDX_ADC:    s_d.prdata = {16'h0000, s_q.adc_dlt, 1'b0, s_q.adc_lvl};
        `IDX_HPCTL:  s_d.prdata = {22'h000000, s_q.drv_r, s_q.drv_l, s_q.hrate,
                                   s_q.hdiv, s_q.range, 1'b0};
        `IDX_HPRES:  s_d.prdata = {6'h00, s_q.hdown, s_q.hcomp, 5'h00, s_q.hup};
        default:     s_d.slverr = 1'b1;
      endcase
    end
    // register writes in the access cycle
    if (wr) begin
      unique case (widx)
        `IDX_CTRL: begin
          s_d.mic_on     = pwdata[0];
          s_d.fsel       = pwdata[3:1];
          s_d.pin_sel    = pwdata[4];
          s_d.ref_sel    = pwdata[6:5];
          s_d.settle     = pwdata[11:8];
          s_d.repeat_dly = pwdata[15:12];
        end
        `IDX_BIAS: begin
          s_d.bon   = pwdata[3:0];
          s_d.bslow = pwdata[7:4];
          s_d.bdis  = pwdata[11:8];
        end
        `IDX_LVLSEL: s_d.lvl_en = {pwdata[7], 2'b00, pwdata[4:0]};
        `IDX_HPCTL: begin
          s_d.range = pwdata[2:1];
          s_d.hdiv  = pwdata[5:3];
          s_d.hrate = pwdata[7:6];
          s_d.drv_l = pwdata[8];
          s_d.drv_r = pwdata[9];
        end
        default: ;
      endcase
    end
    // mic detection sequencer
    unique case (s_q.mst)
      M_IDLE: begin
        if (run) begin
          s_d.dly = 16'd1 << s_q.settle;
          s_d.mst = need_bias ? M_SETTLE : M_MEAS;
        end
      end
      M_SETTLE: begin
        if (ls_tick) begin
          s_d.dly = s_q.dly - 16'd1;
          if (s_q.dly == 16'd1) s_d.mst = M_MEAS;
        end
      end
      M_MEAS: begin
        if (mic_meas_done) begin
          s_d.seen = 1'b1;
          s_d.prev = folded;
          if (s_q.fsel == `FN_ADC) begin
            s_d.adc_lvl = mic_meas_adc;
            s_d.adc_dlt = mic_meas_adc >= s_q.adc_lvl ?
                          8'(mic_meas_adc - s_q.adc_lvl) :
                          8'(s_q.adc_lvl - mic_meas_adc);
            if (s_q.seen) s_d.valid = 1'b1;
          end else if (s_q.seen && folded == s_q.prev) begin
            s_d.band    = band_bits(folded);
            s_d.present = folded != 3'd7;
            s_d.valid   = 1'b1;
          end
          s_d.dly = 16'd1 << s_q.repeat_dly;
          s_d.mst = M_WAIT;
        end
      end
      M_WAIT: begin
        if (ls_tick) begin
          s_d.dly = s_q.dly - 16'd1;
          if (s_q.dly == 16'd1) begin
            s_d.dly = 16'd1 << s_q.settle;
            s_d.mst = need_bias ? M_SETTLE : M_MEAS;
          end
        end
      end
    endcase
    // leaving mic detection drops the sequence and validity
    if (!run) begin
      s_d.mst   = M_IDLE;
      s_d.valid = 1'b0;
      s_d.seen  = 1'b0;
    end
    // phone measurement: sweep pacing and completion
    if (s_q.hst == H_RUN) begin
      s_d.sw_cnt = hp_sweep_step ? 7'd0 : s_q.sw_cnt + 7'd1;
      if (hp_sense_done) begin
        s_d.hst   = H_IDLE;
        s_d.hcomp = 1'b1;
        s_d.hup   = hp_meas_up;
        s_d.hdown = hp_meas_down;
      end
    end
    if (trig_wr) begin
      s_d.hst    = H_RUN;
      s_d.sw_cnt = 7'd0;
      s_d.hcomp  = 1'b0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q        <= '0;
      s_q.lvl_en <= `LVLSEL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence trig_seq;
    trig_wr;
  endsequence
  sequence hp_finish;
    s_q.hst == H_RUN && hp_sense_done && !trig_wr;
  endsequence

  valid_hold_a: assert property (s_q.valid && run |=> s_q.valid)
    else $error("valid dropped while detection on");
  valid_clear_a: assert property (!run |=> !s_q.valid)
    else $error("valid set while detection off");
  present_band_a: assert property (s_q.valid && s_q.fsel == `FN_DISCRETE |->
    s_q.present == (s_q.band != 9'h000))
    else $error("presence disagrees with band");
  band_enabled_a: assert property ((s_q.band &
    ~{s_q.lvl_en[7], 2'b00, s_q.lvl_en[4:0], 1'b1}) == 9'h000)
    else $error("disabled band reported");
  adc_stable_a: assert property (s_q.fsel != `FN_ADC |=>
    $stable(s_q.adc_lvl) && $stable(s_q.adc_dlt))
    else $error("adc result moved outside adc mode");
  bias_auto_a: assert property (s_q.mst == M_MEAS && s_q.ref_sel != 2'd0 |->
    bias_output_en[s_q.ref_sel])
    else $error("bias off during measurement");
  settle_wait_a: assert property (s_q.mst == M_SETTLE && run && !ls_tick |=>
    s_q.mst == M_SETTLE)
    else $error("settle left without tick");
  repeat_wait_a: assert property (s_q.mst == M_WAIT && run && !ls_tick |=>
    s_q.mst == M_WAIT)
    else $error("repeat wait left without tick");
  mic_range_a: assert property (s_q.fsel == `FN_HP_MIC |-> hp_range_out == 2'b00)
    else $error("range used on mic pin");
  trig_start_a: assert property (trig_seq |=> s_q.hst == H_RUN && !s_q.hcomp)
    else $error("trigger did not start measurement");
  hp_measure_complete_a: assert property (hp_finish |=> s_q.hcomp &&
    s_q.hup == $past(hp_meas_up) && s_q.hdown == $past(hp_meas_down))
    else $error("completion not latched");
  done_hold_a: assert property (s_q.hcomp && !trig_wr |=> s_q.hcomp)
    else $error("done flag fell without trigger");

  // measurement completion steps on the mic side, and the phone control register read setup
  sequence mic_finish;
    s_q.mst == M_MEAS && mic_meas_done && run;
  endsequence
  sequence adc_finish;
    mic_finish ##0 s_q.fsel == `FN_ADC;
  endsequence
  sequence hpctl_setup;
    setup && widx == `IDX_HPCTL;
  endsequence

  mic_rest_a: assert property (mic_finish |=> s_q.mst == M_WAIT && !mic_meas_go)
    else $error("no repeat wait after measurement");
  adc_capture_a: assert property (adc_finish |=> s_q.adc_lvl == $past(mic_meas_adc))
    else $error("adc level not captured");
  hp_stop_a: assert property (hp_finish |=> !hp_sense_go)
    else $error("phone measurement kept running");
  trig_read_a: assert property (hpctl_setup |=> !s_q.prdata[0])
    else $error("trigger bit read back as one");
  bias_idle_a: assert property (s_q.mst == M_IDLE |-> bias_output_en == s_q.bon)
    else $error("bias pulsed while idle");
  band_unused_a: assert property (s_q.lvl_en[6:5] == 2'b00)
    else $error("unused band enables set");

endmodule : accessory_impedance_detect

// *** rtl/impdet_consts.svh ***
`ifndef IMPDET_CONSTS_SVH
`define IMPDET_CONSTS_SVH
// register indices; byte address is four times the index
`define IDX_CTRL    10'h2A0
`define IDX_BIAS    10'h2A1
`define IDX_LVLSEL  10'h2A4
`define IDX_STATUS  10'h2A5
`define IDX_ADC     10'h2AB
`define IDX_HPCTL   10'h2B0
`define IDX_HPRES   10'h2B1
// reset values
`define LVLSEL_RST  8'h9F
// detection function codes
`define FN_DISCRETE 3'b000
`define FN_HP_MIC   3'b100
`define FN_ADC      3'b111
// timing: system clock and low-speed measurement clock
`define CLK_HZ      100000000
`define LS_HZ       32000
// status field positions
`define ST_PRESENT  0
`define ST_VALID    1
`define ST_BAND_LO  2
`define HPRES_DONE  15
`endif

// *** rtl/impdet_pkg.sv ***
package impdet_pkg;
  typedef enum logic [1:0] {
    M_IDLE   = 2'b00,
    M_SETTLE = 2'b01,
    M_MEAS   = 2'b10,
    M_WAIT   = 2'b11
  } mic_st_t;
  typedef enum logic {
    H_IDLE = 1'b0,
    H_RUN  = 1'b1
  } hp_st_t;
  typedef struct packed {
    mic_st_t     mst;
    hp_st_t      hst;
    logic [11:0] ls_cnt;
    logic [15:0] dly;
    logic [6:0]  sw_cnt;
    logic        mic_on;
    logic [2:0]  fsel;
    logic        pin_sel;
    logic [1:0]  ref_sel;
    logic [3:0]  settle;
    logic [3:0]  repeat_dly;
    logic [3:0]  bon;
    logic [3:0]  bslow;
    logic [3:0]  bdis;
    logic [7:0]  lvl_en;
    logic [8:0]  band;
    logic        valid;
    logic        present;
    logic [2:0]  prev;
    logic        seen;
    logic [6:0]  adc_lvl;
    logic [7:0]  adc_dlt;
    logic [1:0]  range;
    logic [2:0]  hdiv;
    logic [1:0]  hrate;
    logic        drv_l;
    logic        drv_r;
    logic        hcomp;
    logic [9:0]  hup;
    logic [9:0]  hdown;
    logic [31:0] prdata;
    logic        slverr;
  } state_t;
endpackage : impdet_pkg

// *** sim/headset_front_end_model.sv ***
`timescale 1ns/1ps
module headset_front_end_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // mic sense side
  input  wire logic       mic_meas_go,
  input  wire logic [2:0] band_cfg,
  input  wire logic [6:0] adc_cfg,
  output logic            mic_meas_done,
  output logic      [2:0] mic_meas_band,
  output logic      [6:0] mic_meas_adc,
  // phone sense side
  input  wire logic       hp_sense_go,
  input  wire logic       hp_sweep_step,
  input  wire logic [9:0] up_cfg,
  input  wire logic [9:0] down_cfg,
  output logic            hp_sense_done,
  output logic      [9:0] hp_meas_up,
  output logic      [9:0] hp_meas_down
);
  logic [2:0] mc;
  logic [1:0] hc;
  // results only hold with done, inverted otherwise
  assign mic_meas_band = mic_meas_done ? band_cfg : ~band_cfg;
  assign mic_meas_adc  = mic_meas_done ? adc_cfg : ~adc_cfg;
  assign hp_meas_up    = hp_sense_done ? up_cfg : ~up_cfg;
  assign hp_meas_down  = hp_sense_done ? down_cfg : ~down_cfg;
  // mic load answers five cycles into a request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc <= 3'h0;
      mic_meas_done <= 1'b0;
    end else begin
      mic_meas_done <= mic_meas_go && (mc == 3'h4);
      mc <= !mic_meas_go ? 3'h0 : (mc == 3'h5 ? mc : mc + 3'h1);
    end
  end
  // phone sweep ends on the third current step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hc <= 2'h0;
      hp_sense_done <= 1'b0;
    end else begin
      hp_sense_done <= hp_sense_go && hp_sweep_step && (hc == 2'h2);
      hc <= !hp_sense_go ? 2'h0 : (hp_sweep_step && hc != 2'h3 ? hc + 2'h1 : hc);
    end
  end
endmodule : headset_front_end_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`include "impdet_consts.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        mic_meas_go, sense_pin_select, mic_meas_done;
  logic [2:0]  mic_meas_band, band_cfg, detect_function_select;
  logic [6:0]  mic_meas_adc, adc_cfg;
  logic [3:0]  bias_output_en, bias_slow_ramp, bias_discharge_on;
  logic        hp_sense_go, hp_sweep_step, hp_on_mic_pin, hp_sense_done;
  logic        left_phone_driver_on, right_phone_driver_on;
  logic [1:0]  hp_range_out;
  logic [9:0]  hp_meas_up, hp_meas_down, up_cfg, down_cfg;
  int          fail_count, total_checks, seed, r, dv, rt, n;
  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  accessory_impedance_detect #(.LS_CYC(4)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mic_meas_go(mic_meas_go),
    .sense_pin_select(sense_pin_select), .mic_meas_done(mic_meas_done),
    .mic_meas_band(mic_meas_band), .mic_meas_adc(mic_meas_adc),
    .bias_output_en(bias_output_en), .bias_slow_ramp(bias_slow_ramp),
    .bias_discharge_on(bias_discharge_on), .hp_sense_go(hp_sense_go),
    .hp_sweep_step(hp_sweep_step), .hp_range_out(hp_range_out),
    .hp_on_mic_pin(hp_on_mic_pin), .detect_function_select(detect_function_select),
    .hp_sense_done(hp_sense_done), .hp_meas_up(hp_meas_up), .hp_meas_down(hp_meas_down),
    .left_phone_driver_on(left_phone_driver_on),
    .right_phone_driver_on(right_phone_driver_on));
  headset_front_end_model u_fe (.pclk(pclk), .presetn(presetn), .mic_meas_go(mic_meas_go),
    .band_cfg(band_cfg), .adc_cfg(adc_cfg), .mic_meas_done(mic_meas_done),
    .mic_meas_band(mic_meas_band), .mic_meas_adc(mic_meas_adc), .hp_sense_go(hp_sense_go),
    .hp_sweep_step(hp_sweep_step), .up_cfg(up_cfg), .down_cfg(down_cfg),
    .hp_sense_done(hp_sense_done), .hp_meas_up(hp_meas_up), .hp_meas_down(hp_meas_down));
  // one apb transfer, result left in rd and err
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // read until a bit is set
  task automatic poll(input logic [9:0] idx, input int b);
    rd = 32'h0;
    for (n = 0; n < 300 && rd[b] !== 1'b1; n++) apb(1'b0, idx, 32'h0);
  endtask : poll
  // expected band after folding disabled bands downward
  function automatic int fold(input int b, input logic [7:0] en);
    while (b > 0 && b < 7 && en[(b == 6) ? 7 : b - 1] !== 1'b1) b--;
    return b;
  endfunction : fold
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    report_and_stop;
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {band_cfg, adc_cfg, up_cfg, down_cfg} = '0;
    seed = 32'hb3f8;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `IDX_LVLSEL, 32'h0);
    `CHK("band_en_rst", 32'h9F, rd)
    apb(1'b0, `IDX_ADC, 32'h0);
    `CHK("adc_rst", 32'h0, rd)
    apb(1'b0, `IDX_STATUS, 32'h0);
    `CHK("status_rst", 32'h0, rd)
    apb(1'b0, 10'h2A2, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    apb(1'b1, `IDX_LVLSEL, 32'hFFFFFFFF);
    apb(1'b0, `IDX_LVLSEL, 32'h0);
    `CHK("band_en_wr", 32'h9F, rd)
    // phone measurement on dedicated pin, then on mic pin
    for (int fn = 0; fn <= 4; fn += 4) begin
      r = $random(seed) & 3;
      dv = 4 + ($random(seed) & 3);
      rt = $random(seed) & 3;
      up_cfg <= 169 + ($random(seed) & 511);
      down_cfg <= $random(seed);
      apb(1'b1, `IDX_CTRL, 32'h10 | (fn << 1));
      apb(1'b1, `IDX_HPCTL, (rt << 6) | (dv << 3) | (r << 1) | 1);
      #1;
      `CHK("hp_range", (fn == 4) ? 0 : r, hp_range_out)
      `CHK("drv_off", 2'b00, {left_phone_driver_on, right_phone_driver_on})
      `CHK("fn_sel", fn, detect_function_select)
      `CHK("hp_mic_pin", fn == 4, hp_on_mic_pin)
      `CHK("pin_sel", 1'b1, sense_pin_select)
      apb(1'b0, `IDX_HPRES, 32'h0);
      `CHK("hp_measure_complete_clr", 1'b0, rd[15])
      @(posedge pclk iff hp_sweep_step);
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (hp_sweep_step !== 1'b1 && n < 300);
      `CHK("sweep_period", (dv + 1) << rt, n)
      poll(`IDX_HPRES, 15);
      `CHK("hp_up", up_cfg, rd[9:0])
      `CHK("hp_down", down_cfg, rd[25:16])
      apb(1'b0, `IDX_HPCTL, 32'h0);
      `CHK("trig_rd0", 1'b0, rd[0])
      repeat (20) @(posedge pclk);
      apb(1'b0, `IDX_HPRES, 32'h0);
      `CHK("hp_measure_complete_hold", 1'b1, rd[15])
    end
    // discrete mic detect, 73 ohm band disabled, bias pulsed
    band_cfg <= 3'd3;
    apb(1'b1, `IDX_LVLSEL, 32'h9B);
    apb(1'b1, `IDX_BIAS, 32'h0);
    apb(1'b1, `IDX_CTRL, 32'h1221);
    #1;
    `CHK("bias_dis", 8'h00, {bias_discharge_on, bias_slow_ramp})
    for (n = 0; n < 200 && bias_output_en[1] !== 1'b1; n++) @(posedge pclk);
    `CHK("bias_auto", 1'b1, bias_output_en[1])
    `CHK("settle_first", 1'b0, mic_meas_go)
    poll(`IDX_STATUS, 1);
    `CHK("status_disc", 11'h003 | (11'h004 << fold(3, 8'h9B)), rd[10:0])
    band_cfg <= 3'd7;
    repeat (150) @(posedge pclk);
    apb(1'b0, `IDX_STATUS, 32'h0);
    `CHK("valid_hold", 2'b10, rd[1:0])
    // adc mode, stopped before reading
    adc_cfg <= $random(seed);
    apb(1'b1, `IDX_CTRL, 32'h0);
    apb(1'b1, `IDX_CTRL, 32'h100F);
    poll(`IDX_STATUS, 1);
    apb(1'b1, `IDX_CTRL, 32'hE);
    apb(1'b0, `IDX_ADC, 32'h0);
    `CHK("adc_result", {8'h00, 1'b0, adc_cfg}, rd[15:0])
    report_and_stop;
  end
endmodule : testbench
